// [rtl/uem_top.sv]
/*
  UART interrupt mask and receive error block with a Wishbone slave.
  Holds the event enables, sticky event status, error cause flags and
  the receive holding register. Assumes event_in pulses come from logic
  on clk_in and rxd_in is an asynchronous pin.
*/
// Decided for this implementation: the Wishbone interface to the registers.
// Functional notes
// - disable bit turns CTS interrupts off; reads enable
// - disable bits for receive events, read enable
// - disable bits for transmit events, read enable
// - disable bit for error event, reads enable
// - error flags readable, write one clears
// - start bit while holding full sets overrun
// - bad parity sets parity flag when enabled
// - missing stop bit sets framing flag
// - line low beyond one frame sets break
// - flag reads one while error recorded
// - enable register sets bits, shares state
`timescale 1ns/10ps
module uem_top #(
  parameter int CLKS_PER_BIT = uem_pkg::CLKS_PER_BIT
)(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [11:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // serial receive pin
  input  wire logic        rxd_in,
  // event pulses from the data path, at the event field positions
  input  wire logic [31:0] event_in,
  // interrupt and error event
  output logic             irq_out,
  output logic             error_event_out
);
  if (CLKS_PER_BIT < 4)
    $error("uem_top: CLKS_PER_BIT must be at least 4");

  // byte address decode, word aligned
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  // byte enables to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lanes

  logic        meta_reg, sync_reg;
  logic [31:0] inten_reg, inten_next, stat_reg, stat_next, stat_set;
  logic [31:0] rd_data, wmask;
  logic [3:0]  err_reg, err_next, err_set;
  logic        par_en_reg, par_en_next, full_reg, full_next;
  logic [7:0]  hold_reg, hold_next;
  logic        ack_next, irq_next, take, wr, rd_hold;
  logic        rx_start, rx_done, rx_par, rx_frm, rx_brk;
  logic [7:0]  rx_data;

  // two flops on the pin; only the second is read
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= rxd_in;
      sync_reg <= meta_reg;
    end
  end

  uem_rx #(
    .CLKS_PER_BIT (CLKS_PER_BIT)
  ) u_rx (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .rxd_in          (sync_reg),
    .parity_en_in    (par_en_reg),
    .start_out       (rx_start),
    .done_out        (rx_done),
    .data_out        (rx_data),
    .parity_err_out  (rx_par),
    .framing_err_out (rx_frm),
    .break_out       (rx_brk)
  );

  // bus handshake: an access acts at the edge where ack is seen high
  always_comb
  begin
    ack_next = wb_cyc_in && wb_stb_in && !wb_ack_out;
    take     = wb_cyc_in && wb_stb_in && wb_ack_out;
    wr       = take && wb_we_in;
    wmask    = wb_dat_in & lanes(wb_sel_in);
    rd_hold  = take && !wb_we_in && hit(wb_adr_in, uem_pkg::OFS_RX_DATA);
  end

  // read data, unmapped addresses read as zero
  always_comb
  begin
    rd_data = 32'h00000000;
    if (hit(wb_adr_in, uem_pkg::OFS_INTEN_SET) ||
        hit(wb_adr_in, uem_pkg::OFS_INTEN_CLR))
      rd_data = inten_reg;
    else if (hit(wb_adr_in, uem_pkg::OFS_ERR))
      rd_data = {28'h0000000, err_reg};
    else if (hit(wb_adr_in, uem_pkg::OFS_EVT_STAT))
      rd_data = stat_reg;
    else if (hit(wb_adr_in, uem_pkg::OFS_CONFIG))
      rd_data = {31'h00000000, par_en_reg};
    else if (hit(wb_adr_in, uem_pkg::OFS_RX_DATA))
      rd_data = {23'h000000, full_reg, hold_reg};
  end

  // one enable state reached through set and clear addresses
  always_comb
  begin
    inten_next = inten_reg;
    if (wr && hit(wb_adr_in, uem_pkg::OFS_INTEN_SET))
      inten_next = inten_reg | (wmask & uem_pkg::EVT_MASK);
    else if (wr && hit(wb_adr_in, uem_pkg::OFS_INTEN_CLR))
      inten_next = inten_reg & ~wmask;
    par_en_next = par_en_reg;
    if (wr && hit(wb_adr_in, uem_pkg::OFS_CONFIG))
      par_en_next = wmask[uem_pkg::CFG_PARITY];
  end

  // error causes; a new error beats a clear in the same cycle
  always_comb
  begin
    err_set = 4'h0;
    err_set[uem_pkg::ERR_OVERRUN] = rx_start && full_reg && !rd_hold;
    err_set[uem_pkg::ERR_PARITY]  = rx_par;
    err_set[uem_pkg::ERR_FRAMING] = rx_frm;
    err_set[uem_pkg::ERR_BREAK]   = rx_brk;
    err_next = err_reg;
    if (wr && hit(wb_adr_in, uem_pkg::OFS_ERR))
      err_next = err_reg & ~wmask[3:0];
    err_next = err_next | err_set;
  end

  // holding register: the next character overwrites an unread one
  always_comb
  begin
    hold_next = rx_done ? rx_data : hold_reg;
    full_next = rx_done || (full_reg && !rd_hold);
  end

  // sticky event status, write one to clear, set wins
  always_comb
  begin
    stat_set = event_in;
    stat_set[uem_pkg::BIT_RX_READY] = event_in[uem_pkg::BIT_RX_READY] ||
                                      rx_done;
    stat_set[uem_pkg::BIT_ERROR] = event_in[uem_pkg::BIT_ERROR] ||
                                   (|err_set);
    stat_next = stat_reg;
    if (wr && hit(wb_adr_in, uem_pkg::OFS_EVT_CLR))
      stat_next = stat_reg & ~wmask;
    stat_next = stat_next | (stat_set & uem_pkg::EVT_MASK);
    // level output lags the status by one cycle to come from a flop
    irq_next = |(stat_reg & inten_reg);
  end

  // registers
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      inten_reg       <= uem_pkg::INTEN_RST;
      err_reg         <= uem_pkg::ERR_RST;
      stat_reg        <= 32'h00000000;
      par_en_reg      <= 1'b0;
      hold_reg        <= 8'h00;
      full_reg        <= 1'b0;
      wb_ack_out      <= 1'b0;
      wb_dat_out      <= 32'h00000000;
      irq_out         <= 1'b0;
      error_event_out <= 1'b0;
    end
    else
    begin
      inten_reg       <= inten_next;
      err_reg         <= err_next;
      stat_reg        <= stat_next;
      par_en_reg      <= par_en_next;
      hold_reg        <= hold_next;
      full_reg        <= full_next;
      wb_ack_out      <= ack_next;
      wb_dat_out      <= (ack_next && !wb_we_in) ? rd_data : 32'h00000000;
      irq_out         <= irq_next;
      error_event_out <= |err_set;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_wr_clr;
    wr && hit(wb_adr_in, uem_pkg::OFS_INTEN_CLR) && wb_sel_in == 4'hF;
  endsequence
  sequence s_wr_set;
    wr && hit(wb_adr_in, uem_pkg::OFS_INTEN_SET) && wb_sel_in == 4'hF;
  endsequence
  sequence s_rd_err;
    ack_next && !wb_we_in && hit(wb_adr_in, uem_pkg::OFS_ERR);
  endsequence

  a_cts_disable: assert property (
    s_wr_clr and wb_dat_in[uem_pkg::BIT_CTS_GONE] |=>
      !inten_reg[uem_pkg::BIT_CTS_GONE])
    else $error("clear-to-send enable survived a disable write");
  a_rx_disable: assert property (
    s_wr_clr and wb_dat_in[uem_pkg::BIT_RX_READY] |=>
      !inten_reg[uem_pkg::BIT_RX_READY] && !irq_next ||
      inten_reg[uem_pkg::BIT_RX_READY] == 1'b0)
    else $error("receive enable survived a disable write");
  a_tx_keep: assert property (
    s_wr_clr and !wb_dat_in[uem_pkg::BIT_TX_HALTED] |=>
      inten_reg[uem_pkg::BIT_TX_HALTED] ==
      $past(inten_reg[uem_pkg::BIT_TX_HALTED]))
    else $error("zero write changed a transmit enable");
  a_err_disable: assert property (
    s_wr_clr and wb_dat_in[uem_pkg::BIT_ERROR] |=>
      !inten_reg[uem_pkg::BIT_ERROR] ##1 !irq_out || inten_reg != 0)
    else $error("error enable survived a disable write");
  a_enable_set: assert property (
    s_wr_set and wb_dat_in[uem_pkg::BIT_TX_SENT] |=>
      inten_reg[uem_pkg::BIT_TX_SENT])
    else $error("enable write did not set the bit");
  a_err_w1c: assert property (
    wr && hit(wb_adr_in, uem_pkg::OFS_ERR) && wb_sel_in[0] &&
    wb_dat_in[3:0] == 4'hF && err_set == 4'h0 |=> err_reg == 4'h0)
    else $error("error flags not cleared by a one write");
  a_overrun_set: assert property (
    rx_start && full_reg && !rd_hold |=>
      err_reg[uem_pkg::ERR_OVERRUN] ##1 error_event_out == 1'b0 ||
      err_reg[uem_pkg::ERR_OVERRUN])
    else $error("overrun not recorded");
  a_parity_off: assert property (
    (!par_en_reg && $stable(par_en_reg)) [*3] |-> !rx_par)
    else $error("parity error with checking off");
  a_flag_read: assert property (
    s_rd_err |=> wb_dat_out[3:0] == $past(err_reg))
    else $error("error read does not show the flags");
  a_err_event: assert property (
    (|err_set) |=> error_event_out && stat_reg[uem_pkg::BIT_ERROR])
    else $error("new error raised no error event");
  a_break_flag: assert property (
    rx_brk |=> err_reg[uem_pkg::ERR_BREAK])
    else $error("break not recorded");
  a_frame_flag: assert property (
    rx_frm |=> err_reg[uem_pkg::ERR_FRAMING])
    else $error("framing fault not recorded");

  // handshake in two steps: a fresh request, then one lone ack
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack_once;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  a_bus_answer: assert property (
    s_req |=> s_ack_once)
    else $error("request not answered by a single ack");
  a_rd_idle: assert property (
    !wb_ack_out |-> wb_dat_out == 32'h00000000)
    else $error("read data shown outside the ack cycle");

  // enable state: the exact effect of full-word writes, and no drift
  a_clr_exact: assert property (
    s_wr_clr |=> inten_reg == ($past(inten_reg) & ~$past(wb_dat_in)))
    else $error("disable write did not clear exactly its ones");
  a_set_exact: assert property (
    s_wr_set |=> inten_reg ==
      ($past(inten_reg) | ($past(wb_dat_in) & uem_pkg::EVT_MASK)))
    else $error("enable write did not set exactly its ones");
  a_mask_only: assert property (
    (inten_reg & ~uem_pkg::EVT_MASK) == 32'h00000000)
    else $error("enable bit outside the event fields");
  a_enable_keep: assert property (
    !wr |=> inten_reg == $past(inten_reg))
    else $error("enable state moved without a write");
  a_read_enable: assert property (
    ack_next && !wb_we_in && hit(wb_adr_in, uem_pkg::OFS_INTEN_CLR) |=>
      wb_dat_out == $past(inten_reg))
    else $error("disable register does not read the enables");

  // interrupt level: enabled status, one cycle late so it leaves a flop
  a_irq_level: assert property (
    irq_out == $past(|(stat_reg & inten_reg)))
    else $error("interrupt level does not match enabled status");
  a_stat_sticky: assert property (
    stat_reg[uem_pkg::BIT_ERROR] &&
    !(wr && hit(wb_adr_in, uem_pkg::OFS_EVT_CLR)) |=>
      stat_reg[uem_pkg::BIT_ERROR])
    else $error("error status dropped without a clear");
  a_event_cause: assert property (
    error_event_out |-> $past(err_set) != 4'h0)
    else $error("error event without a new fault");

  // error flags: sticky until a one is written, and a set beats a clear
  a_err_keep: assert property (
    wr && hit(wb_adr_in, uem_pkg::OFS_ERR) && wb_dat_in[3:0] == 4'h0 |=>
      err_reg == ($past(err_reg) | $past(err_set)))
    else $error("zero write changed the error flags");
  a_err_hold: assert property (
    !(wr && hit(wb_adr_in, uem_pkg::OFS_ERR)) |=>
      (err_reg & $past(err_reg)) == $past(err_reg))
    else $error("error flag dropped without a clear");
  a_set_wins: assert property (
    err_set != 4'h0 |=> (err_reg & $past(err_set)) == $past(err_set))
    else $error("new error lost to a clear in the same cycle");
  a_par_flag: assert property (
    rx_par |=> err_reg[uem_pkg::ERR_PARITY])
    else $error("parity fault not recorded");
  a_par_needs_en: assert property (
    rx_par |-> $past(par_en_reg))
    else $error("parity fault reported with checking off");

  // holding register: load, release by a read, overrun only when full
  a_hold_load: assert property (
    rx_done |=> full_reg && hold_reg == $past(rx_data))
    else $error("received character not held");
  a_hold_free: assert property (
    rd_hold && !rx_done |=> !full_reg)
    else $error("read did not free the holding register");
  a_no_overrun: assert property (
    rx_start && !full_reg && !err_reg[uem_pkg::ERR_OVERRUN] |=>
      !err_reg[uem_pkg::ERR_OVERRUN])
    else $error("overrun flagged with the holding register empty");
endmodule : uem_top

// [rtl/uem_pkg.sv]
/*
  Constants shared by the UART error and interrupt mask block: register
  offsets, field positions, reset values and receiver timing.
  Assumes a 40 MHz system clock and byte addresses on a 12-bit bus.
*/
package uem_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_INTEN_SET = 12'h304;
  localparam logic [11:0] OFS_INTEN_CLR = 12'h308;
  localparam logic [11:0] OFS_ERR       = 12'h480;
  localparam logic [11:0] OFS_EVT_STAT  = 12'h600;
  localparam logic [11:0] OFS_EVT_CLR   = 12'h604;
  localparam logic [11:0] OFS_CONFIG    = 12'h608;
  localparam logic [11:0] OFS_RX_DATA   = 12'h60C;
  // event field positions, shared by enable, disable and status
  localparam int BIT_CTS       = 0;
  localparam int BIT_CTS_GONE  = 1;
  localparam int BIT_RX_READY  = 2;
  localparam int BIT_RX_DONE   = 4;
  localparam int BIT_TX_SENT   = 7;
  localparam int BIT_TX_DONE   = 8;
  localparam int BIT_ERROR     = 9;
  localparam int BIT_RX_TMO    = 17;
  localparam int BIT_RX_BEGUN  = 19;
  localparam int BIT_TX_BEGUN  = 20;
  localparam int BIT_TX_HALTED = 22;
  localparam logic [31:0] EVT_MASK = 32'h005A0397;
  // error cause and configuration field positions
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_PARITY  = 1;
  localparam int ERR_FRAMING = 2;
  localparam int ERR_BREAK   = 3;
  localparam int CFG_PARITY  = 0;
  // reset values
  localparam logic [31:0] INTEN_RST = 32'h00000000;
  localparam logic [3:0]  ERR_RST   = 4'h0;
  // timing: line rate and frame lengths in bit periods
  localparam int CLK_HZ       = 40000000;
  localparam int BAUD_HZ      = 115200;
  localparam int CLKS_PER_BIT = CLK_HZ / BAUD_HZ;
  localparam int FRAME_BITS   = 10;
  localparam int FRAME_BITS_P = 11;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } uem_rx_state_t;
endpackage : uem_pkg

// [rtl/uem_rx.sv]
/*
  Serial receiver for the error block: frames characters, checks parity
  and stop bit and watches for a break.
  Assumes rxd_in is already synchronised to clk_in.
*/
`timescale 1ns/10ps
module uem_rx #(
  parameter int CLKS_PER_BIT = uem_pkg::CLKS_PER_BIT
)(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  // line and setup
  input  wire logic       rxd_in,
  input  wire logic       parity_en_in,
  // results; data_out holds the last character, the rest are one-cycle pulses
  output logic            start_out,
  output logic            done_out,
  output logic [7:0]      data_out,
  output logic            parity_err_out,
  output logic            framing_err_out,
  output logic            break_out
);
  localparam int LIM = uem_pkg::FRAME_BITS_P * CLKS_PER_BIT;
  localparam int CW  = $clog2(LIM + 2);
  localparam logic [CW-1:0] BIT_END  = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] HALF_END = CW'(CLKS_PER_BIT / 2 - 1);
  localparam logic [CW-1:0] BRK_NP =
    CW'(uem_pkg::FRAME_BITS * CLKS_PER_BIT + 1);
  localparam logic [CW-1:0] BRK_P = CW'(LIM + 1);

  uem_pkg::uem_rx_state_t st_reg, st_next;
  logic [CW-1:0] cnt_reg, cnt_next, low_reg, low_next, brk_lim;
  logic [2:0]    idx_reg, idx_next;
  logic [7:0]    sh_reg, sh_next;
  logic          par_reg, par_next;
  logic          start_next, done_next, frm_next, brk_next;

  // frame sequencer; a glitch shorter than half a bit is dropped
  always_comb
  begin
    st_next    = st_reg;
    cnt_next   = cnt_reg + 1'b1;
    idx_next   = idx_reg;
    sh_next    = sh_reg;
    par_next   = par_reg;
    start_next = 1'b0;
    done_next  = 1'b0;
    frm_next   = 1'b0;
    case (st_reg)
      uem_pkg::RX_IDLE:
      begin
        cnt_next = '0;
        if (!rxd_in)
          st_next = uem_pkg::RX_START;
      end
      // a start counts only once confirmed at mid bit, so the low tail
      // of a bad stop bit cannot pass for a new character (overrun)
      uem_pkg::RX_START:
        if (cnt_reg == HALF_END)
        begin
          cnt_next   = '0;
          idx_next   = 3'h0;
          start_next = !rxd_in;
          st_next    = rxd_in ? uem_pkg::RX_IDLE : uem_pkg::RX_DATA;
        end
      uem_pkg::RX_DATA:
        if (cnt_reg == BIT_END)
        begin
          cnt_next = '0;
          sh_next  = {rxd_in, sh_reg[7:1]};
          idx_next = idx_reg + 3'h1;
          if (idx_reg == 3'h7)
            st_next = parity_en_in ? uem_pkg::RX_PARITY : uem_pkg::RX_STOP;
        end
      uem_pkg::RX_PARITY:
        if (cnt_reg == BIT_END)
        begin
          cnt_next = '0;
          par_next = (^sh_reg) ^ rxd_in;
          st_next  = uem_pkg::RX_STOP;
        end
      uem_pkg::RX_STOP:
        if (cnt_reg == BIT_END)
        begin
          done_next = 1'b1;
          frm_next  = !rxd_in;
          st_next   = uem_pkg::RX_IDLE;
        end
      default:
        st_next = uem_pkg::RX_IDLE;
    endcase
  end

  // break: low for more cycles than one whole frame, reported once
  always_comb
  begin
    brk_lim  = parity_en_in ? BRK_P : BRK_NP;
    low_next = rxd_in ? '0 : (low_reg == brk_lim ? low_reg : low_reg + 1'b1);
    brk_next = !rxd_in && (low_reg == brk_lim - 1'b1);
  end

  // state registers
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_reg          <= uem_pkg::RX_IDLE;
      cnt_reg         <= '0;
      low_reg         <= '0;
      idx_reg         <= 3'h0;
      sh_reg          <= 8'h00;
      par_reg         <= 1'b0;
      start_out       <= 1'b0;
      done_out        <= 1'b0;
      data_out        <= 8'h00;
      parity_err_out  <= 1'b0;
      framing_err_out <= 1'b0;
      break_out       <= 1'b0;
    end
    else
    begin
      st_reg          <= st_next;
      cnt_reg         <= cnt_next;
      low_reg         <= low_next;
      idx_reg         <= idx_next;
      sh_reg          <= sh_next;
      par_reg         <= par_next;
      start_out       <= start_next;
      done_out        <= done_next;
      data_out        <= done_next ? sh_reg : data_out;
      parity_err_out  <= done_next && parity_en_in && par_reg;
      framing_err_out <= frm_next;
      break_out       <= brk_next;
    end
  end
endmodule : uem_rx

// [verification/uem_line_model.sv]
/*
  Remote serial transmitter driving the block's receive line.
  Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/10ps
module uem_line_model #(
  parameter int CPB = 8
)(
  input  wire logic clk_in,
  output logic      rxd_out
);
  // idle high, as a pulled-up line rests between frames
  initial rxd_out = 1'b1;

  // one bit period, changed only just after an edge
  task automatic bit_out(input logic b);
    rxd_out <= b;
    repeat (CPB) @(posedge clk_in);
  endtask : bit_out

  // 8-bit frame, lsb first, optional even parity, optional faults
  task automatic send(input logic [7:0] d, input logic par,
                      input logic bad_par, input logic bad_stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++)
      bit_out(d[i]);
    if (par)
      bit_out(^d ^ bad_par);
    bit_out(~bad_stop);
    bit_out(1'b1);
  endtask : send

  // line held low for n bit periods, then idle for one
  task automatic hold_low(input int n);
    rxd_out <= 1'b0;
    repeat (n * CPB) @(posedge clk_in);
    bit_out(1'b1);
  endtask : hold_low
endmodule : uem_line_model

// [verification/tb_top.sv]
/*
  Self-checking bench for the uart error and interrupt mask block.
  Assumes the line model and a block built with 8 clocks per bit.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int CPB = 8;
  // bench signals
  logic        clk_in;
  logic        sys_rst_in;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [31:0] dat;
  logic [31:0] rd;
  logic        ack;
  logic        rxd;
  logic [31:0] event_in;
  logic        irq;
  logic        err_ev;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] en;
  logic [31:0] s;
  int          error_cnt;
  int          n_compared;
  int          ev_cnt;

  uem_top #(
    .CLKS_PER_BIT (CPB)
  ) u_uem_top (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .wb_cyc_in       (cyc),
    .wb_stb_in       (stb),
    .wb_we_in        (we),
    .wb_adr_in       (adr),
    .wb_sel_in       (4'hF),
    .wb_dat_in       (dat),
    .wb_dat_out      (rd),
    .wb_ack_out      (ack),
    .rxd_in          (rxd),
    .event_in        (event_in),
    .irq_out         (irq),
    .error_event_out (err_ev)
  );

  uem_line_model #(
    .CPB (CPB)
  ) u_uem_line_model (
    .clk_in  (clk_in),
    .rxd_out (rxd)
  );

  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  // error event pulses counted as they appear
  always @(posedge clk_in)
    if (err_ev === 1'b1)
      ev_cnt <= ev_cnt + 1;

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // enable state after a set write then a clear write
  function automatic logic [31:0] en_exp(input logic [31:0] e, st, cl);
    return (e | (st & uem_pkg::EVT_MASK)) & ~cl;
  endfunction : en_exp

  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // classic single cycle; waits on ack, never on a cycle count
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    // only the watchdog ends a wait that never gets its ack
    do
      @(posedge clk_in);
    while (ack !== 1'b1);
    chk("ack", {31'h0, ack}, 32'h1);
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask : wb

  task automatic pulse(input logic [31:0] m);
    event_in <= m;
    @(posedge clk_in);
    event_in <= 32'h0;
    repeat (2) @(posedge clk_in);
  endtask : pulse

  // one frame, holding register drained, flags checked then cleared
  task automatic fault(input logic p, bp, bs, input logic [31:0] e);
    logic [31:0] r;
    int c0;
    c0 = ev_cnt;
    wb(1'b1, uem_pkg::OFS_CONFIG, {31'h0, p}, r);
    seed = xs(seed);
    u_uem_line_model.send(seed[7:0], p, bp, bs);
    wb(1'b0, uem_pkg::OFS_RX_DATA, 32'h0, r);
    wb(1'b0, uem_pkg::OFS_ERR, 32'h0, r);
    chk("error flags", r, e);
    chk("error event", {31'h0, ev_cnt != c0}, {31'h0, e != 0});
    chk("error irq", {31'h0, irq}, {31'h0, e != 0});
    wb(1'b1, uem_pkg::OFS_ERR, 32'h0, r);
    wb(1'b0, uem_pkg::OFS_ERR, 32'h0, r);
    chk("flags after zero write", r, e);
    wb(1'b1, uem_pkg::OFS_ERR, e, r);
    wb(1'b0, uem_pkg::OFS_ERR, 32'h0, r);
    chk("flags after clear", r, 32'h0);
    wb(1'b1, uem_pkg::OFS_EVT_CLR, 32'hFFFFFFFF, r);
  endtask : fault

  // watchdog: far beyond the length of the sequence below
  initial
  begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    conclude();
  end

  initial
  begin
    clk_in = 1'b0;
    sys_rst_in = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    dat = 32'h0;
    event_in = 32'h0;
    seed = 32'h0000004A;
    error_cnt = 0;
    n_compared = 0;
    ev_cnt = 0;
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    // reset values and an unmapped place
    wb(1'b0, uem_pkg::OFS_INTEN_CLR, 32'h0, q);
    chk("mask reset", q, 32'h0);
    wb(1'b0, uem_pkg::OFS_ERR, 32'h0, q);
    chk("flags reset", q, 32'h0);
    wb(1'b0, 12'h100, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // all on, a zero clear, then random set and clear patterns
    en = uem_pkg::EVT_MASK;
    wb(1'b1, uem_pkg::OFS_INTEN_SET, 32'hFFFFFFFF, q);
    wb(1'b1, uem_pkg::OFS_INTEN_CLR, 32'h0, q);
    repeat (8)
    begin
      wb(1'b0, uem_pkg::OFS_INTEN_CLR, 32'h0, q);
      chk("disable readback", q, en);
      wb(1'b0, uem_pkg::OFS_INTEN_SET, 32'h0, q);
      chk("enable readback", q, en);
      seed = xs(seed);
      s = seed;
      seed = xs(seed);
      wb(1'b1, uem_pkg::OFS_INTEN_SET, s, q);
      wb(1'b1, uem_pkg::OFS_INTEN_CLR, seed, q);
      en = en_exp(en, s, seed);
    end
    wb(1'b1, uem_pkg::OFS_INTEN_CLR, 32'hFFFFFFFF, q);
    // each event: masked, enabled, disabled, cleared
    for (int b = 0; b < 32; b++)
      if (uem_pkg::EVT_MASK[b])
      begin
        s = 32'h1 << b;
        pulse(s);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wb(1'b1, uem_pkg::OFS_INTEN_SET, s, q);
        repeat (2) @(posedge clk_in);
        chk("irq enabled", {31'h0, irq}, 32'h1);
        wb(1'b1, uem_pkg::OFS_INTEN_CLR, s, q);
        repeat (2) @(posedge clk_in);
        chk("irq disabled", {31'h0, irq}, 32'h0);
        wb(1'b1, uem_pkg::OFS_EVT_CLR, s, q);
      end
    wb(1'b1, uem_pkg::OFS_INTEN_SET, 32'h1 << uem_pkg::BIT_ERROR, q);
    // clean frames, with and without parity, then the data read back
    for (int p = 0; p < 2; p++)
    begin
      wb(1'b1, uem_pkg::OFS_CONFIG, p, q);
      seed = xs(seed);
      s = seed;
      u_uem_line_model.send(s[7:0], p[0], 1'b0, 1'b0);
      wb(1'b0, uem_pkg::OFS_RX_DATA, 32'h0, q);
      chk("rx holding", q, {23'h0, 1'b1, s[7:0]});
      fault(p[0], 1'b0, 1'b0, 32'h0);
    end
    fault(1'b1, 1'b1, 1'b0, 32'h2);
    fault(1'b0, 1'b0, 1'b1, 32'h4);
    fault(1'b1, 1'b0, 1'b1, 32'h4);
    // second character lands on an unread one; parity off for both
    wb(1'b1, uem_pkg::OFS_CONFIG, 32'h0, q);
    u_uem_line_model.send(8'h5A, 1'b0, 1'b0, 1'b0);
    fault(1'b0, 1'b0, 1'b0, 32'h1);
    // low for exactly one parity frame: framing only, no break
    wb(1'b1, uem_pkg::OFS_CONFIG, 32'h1, q);
    u_uem_line_model.hold_low(11);
    wb(1'b0, uem_pkg::OFS_ERR, 32'h0, q);
    chk("no break at frame", q, 32'h4);
    wb(1'b1, uem_pkg::OFS_ERR, 32'hF, q);
    wb(1'b0, uem_pkg::OFS_RX_DATA, 32'h0, q);
    // low past a plain frame: break
    wb(1'b1, uem_pkg::OFS_CONFIG, 32'h0, q);
    u_uem_line_model.hold_low(12);
    wb(1'b0, uem_pkg::OFS_ERR, 32'h0, q);
    chk("break flag", q & 32'h8, 32'h8);
    conclude();
  end
endmodule : tb_top
